// [sim/ccs_status_regs_monitor.sv]
// assertion checker for the core status registers
`timescale 1ns/1ps
module ccs_status_regs_monitor (
  input wire logic clk, // clock
  input wire logic srst, // reset
  input wire logic ce, // enable
  input wire logic [7:0] sfrAddr, // address
  input wire logic sfrWrEn, // write
  input wire logic sfrRdEn, // read
  input wire logic [7:0] sfrRdData, // read data
  input wire logic sfrRdHit, // read hit
  input wire logic [7:0] bitAddr, // bit address
  input wire logic bitWrEn, // bit write
  input wire logic pushReq, // push
  input wire logic [7:0] stackAddr, // push address
  input wire ccs_pkg::ccs_alu_op_type aluOp, // operation
  input wire logic [7:0] aluOperand, // add operand
  input wire logic [2:0] regIndex, // register number
  input wire logic [7:0] gprAddr, // register address
  input wire logic ptrSel, // pointer pick
  input wire logic [7:0] ptrAddr, // pointer address
  input wire logic [7:0] primaryOut, // accumulator
  input wire logic [7:0] secondOut, // second accumulator
  input wire logic [7:0] statusOut, // status word
  input wire logic [7:0] stackTopOut // stack pointer
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [8:0] addSum;
  logic [4:0] nibSum;
  logic addCarry;
  logic nibCarry;
  logic stWr;
  assign addSum = {1'b0, primaryOut} + {1'b0, aluOperand};
  assign nibSum = {1'b0, primaryOut[3:0]} + {1'b0, aluOperand[3:0]};
  assign addCarry = addSum[8];
  assign nibCarry = nibSum[4];
  // software writes to the status byte, by byte or by bit
  assign stWr = (sfrWrEn && sfrAddr == ccs_pkg::ADDR_STATUS) || (bitWrEn && bitAddr[7:3] == 5'h1a);
  AST_PUSH: assert property (ce && pushReq && !sfrWrEn |=>
    stackTopOut == $past(stackTopOut) + 8'h01 && stackAddr == stackTopOut)
    else $error("push did not pre-increment");
  AST_RESET: assert property ($fell(srst) |-> stackTopOut == 8'h07 &&
    primaryOut == 8'h00 && secondOut == 8'h00 && statusOut == 8'h00)
    else $error("wrong reset value");
  AST_PARITY: assert property (statusOut[0] == ^primaryOut)
    else $error("parity does not follow accumulator");
  AST_ADD_CARRY: assert property (ce && aluOp == ccs_pkg::ALU_ADD |=>
    statusOut[7] == $past(addCarry) && statusOut[6] == $past(nibCarry))
    else $error("add carry flags wrong");
  AST_MUL_WRAP: assert property (ce && aluOp == ccs_pkg::ALU_MUL |=>
    statusOut[2] == ($past(primaryOut) * $past(secondOut) > 16'd255) && !statusOut[7])
    else $error("multiply overflow flag wrong");
  AST_DIV_ZERO: assert property (ce && aluOp == ccs_pkg::ALU_DIV |=>
    statusOut[2] == ($past(secondOut) == 8'h00))
    else $error("divide overflow flag wrong");
  AST_USER_FLAGS: assert property (!stWr |=> $stable(statusOut[5]) && $stable(statusOut[1]))
    else $error("user flag changed by hardware");
  AST_BANK: assert property (ce |=> gprAddr == {3'b000, statusOut[4:3], $past(regIndex)} &&
    ptrAddr == {3'b000, statusOut[4:3], 2'b00, $past(ptrSel)})
    else $error("bank mapping wrong");
  AST_SP_READ: assert property (ce && sfrRdEn && sfrAddr == ccs_pkg::ADDR_STACK_TOP |=>
    sfrRdHit && sfrRdData == $past(stackTopOut))
    else $error("stack pointer read wrong");
  COV_PUSH: cover property (ce && pushReq);
  COV_MUL: cover property (ce && aluOp == ccs_pkg::ALU_MUL);
  COV_DIV0: cover property (ce && aluOp == ccs_pkg::ALU_DIV && secondOut == 8'h00);
endmodule // ccs_status_regs_monitor

bind ccs_status_regs ccs_status_regs_monitor u_mon (.clk, .srst, .ce, .sfrAddr, .sfrWrEn,
  .sfrRdEn, .sfrRdData, .sfrRdHit, .bitAddr, .bitWrEn, .pushReq, .stackAddr, .aluOp,
  .aluOperand, .regIndex, .gprAddr, .ptrSel, .ptrAddr, .primaryOut, .secondOut, .statusOut,
  .stackTopOut);

// [sim/cpu_core_status_registers_test.sv]
// self-checking bench for the core status registers
`timescale 1ns/1ps
module cpu_core_status_registers_test;
  localparam logic [31:0] SID = 32'h1234_abcd; // arbitrary id
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, sfrWrEn = 1'b0, sfrRdEn = 1'b0, bitWrEn = 1'b0;
  logic bitWrVal = 1'b0, bitRdEn = 1'b0, pushReq = 1'b0, popReq = 1'b0, ptrSel = 1'b1;
  logic [7:0] sfrAddr = 8'h00, sfrPage = 8'h00, sfrWrData = 8'h00, bitAddr = 8'h00;
  logic [7:0] aluOperand = 8'h00, sfrRdData, stackAddr, gprAddr, ptrAddr;
  logic [7:0] primaryOut, secondOut, statusOut, stackTopOut;
  logic [2:0] regIndex = 3'h5;
  logic sfrRdHit, bitRdData;
  logic [31:0] serialIdOut;
  ccs_pkg::ccs_alu_op_type aluOp = ccs_pkg::ALU_NONE;
  int mismatches = 0;
  int nTests = 0;
  ccs_status_regs #(.SERIAL_ID(SID)) uut (.clk, .srst, .ce, .sfrAddr, .sfrPage, .sfrWrEn,
    .sfrWrData, .sfrRdEn, .sfrRdData, .sfrRdHit, .bitAddr, .bitWrEn, .bitWrVal, .bitRdEn,
    .bitRdData, .pushReq, .popReq, .stackAddr, .aluOp, .aluOperand, .regIndex, .gprAddr,
    .ptrSel, .ptrAddr, .primaryOut, .secondOut, .statusOut, .stackTopOut, .serialIdOut);
  always #20 clk = ~clk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    nTests++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one strobe cycle then one idle cycle, so no strobe is driven twice in a step
  task automatic tick;
    @(negedge clk);
    {sfrWrEn, sfrRdEn, bitWrEn, bitRdEn, pushReq, popReq} = 6'h00;
    aluOp = ccs_pkg::ALU_NONE;
    @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrEn = 1'b1;
    tick;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    sfrAddr = a;
    sfrRdEn = 1'b1;
    tick;
    chk(sfrRdData, e);
    chk(sfrRdHit, h);
  endtask
  task automatic alu(input ccs_pkg::ccs_alu_op_type o, input logic [7:0] v,
    input logic [7:0] ea, input logic [7:0] eb, input logic [7:0] es);
    aluOp = o;
    aluOperand = v;
    tick;
    chk({primaryOut, secondOut, statusOut}, {ea, eb, es});
  endtask
  task automatic summarize;
    if (mismatches == 0 && nTests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    summarize;
  end
  initial begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk({stackTopOut, primaryOut, secondOut, statusOut}, 32'h0700_0000);
    chk(serialIdOut, SID);
    rd(ccs_pkg::ADDR_STACK_TOP, 8'h07, 1'b1);
    pushReq = 1'b1;
    tick;
    chk({stackTopOut, stackAddr}, 16'h0808);
    wr(ccs_pkg::ADDR_STACK_TOP, 8'hff);
    pushReq = 1'b1;
    tick;
    chk({stackTopOut, stackAddr}, 16'h0000);
    popReq = 1'b1;
    tick;
    chk({stackTopOut, stackAddr}, 16'hff00);
    ce = 1'b0;
    pushReq = 1'b1;
    tick;
    ce = 1'b1;
    chk(stackTopOut, 8'hff);
    wr(ccs_pkg::ADDR_PRIMARY, 8'h7f);
    chk(statusOut, 8'h01);
    alu(ccs_pkg::ALU_ADD, 8'h01, 8'h80, 8'h00, 8'h45);
    alu(ccs_pkg::ALU_ADD, 8'h80, 8'h00, 8'h00, 8'h84);
    alu(ccs_pkg::ALU_ADD_WITH_CARRY_OP, 8'h0f, 8'h10, 8'h00, 8'h41);
    alu(ccs_pkg::ALU_SUBTRACT_WITH_BORROW_OP, 8'h01, 8'h0f, 8'h00, 8'h40);
    alu(ccs_pkg::ALU_SUBTRACT_WITH_BORROW_OP, 8'h10, 8'hff, 8'h00, 8'h80);
    wr(ccs_pkg::ADDR_PRIMARY, 8'h0f);
    wr(ccs_pkg::ADDR_SECOND, 8'h11);
    alu(ccs_pkg::ALU_MUL, 8'h00, 8'hff, 8'h00, 8'h00);
    wr(ccs_pkg::ADDR_SECOND, 8'h10);
    alu(ccs_pkg::ALU_MUL, 8'h00, 8'hf0, 8'h0f, 8'h04);
    alu(ccs_pkg::ALU_DIV, 8'h00, 8'h10, 8'h00, 8'h01);
    alu(ccs_pkg::ALU_DIV, 8'h00, 8'h10, 8'h00, 8'h05);
    for (int b = 0; b < 4; b++) begin
      wr(ccs_pkg::ADDR_STATUS, {3'b000, b[1:0], 3'b000});
      chk({gprAddr, ptrAddr}, {3'b000, b[1:0], 6'b101000, b[1:0], 3'b001});
    end
    wr(ccs_pkg::ADDR_STATUS, 8'h22);
    chk(statusOut, 8'h23);
    bitAddr = 8'hd5;
    bitWrEn = 1'b1;
    tick;
    chk(statusOut, 8'h03);
    bitAddr = 8'hd0;
    bitWrEn = 1'b1;
    tick;
    chk(statusOut, 8'h03);
    alu(ccs_pkg::ALU_ADD, 8'h00, 8'h10, 8'h00, 8'h03);
    bitAddr = 8'he4;
    bitRdEn = 1'b1;
    tick;
    chk(bitRdData, 1'b1);
    bitAddr = 8'hf7;
    bitWrVal = 1'b1;
    bitWrEn = 1'b1;
    tick;
    chk(secondOut, 8'h80);
    sfrPage = ccs_pkg::SERIAL_PAGE;
    for (int i = 0; i < 4; i++) rd(8'(8'hf9 + i), SID[8 * i +: 8], 1'b1);
    wr(ccs_pkg::ADDR_SERIAL3, 8'h33);
    chk(serialIdOut, {8'h33, SID[23:0]});
    sfrPage = 8'h00;
    rd(ccs_pkg::ADDR_SERIAL3, 8'h00, 1'b0);
    wr(ccs_pkg::ADDR_SERIAL3, 8'h44);
    chk(serialIdOut, {8'h33, SID[23:0]});
    rd(8'h82, 8'h00, 1'b0);
    rd(ccs_pkg::ADDR_STATUS, 8'h03, 1'b1);
    srst = 1'b1;
    tick;
    srst = 1'b0;
    @(negedge clk);
    chk({stackTopOut, statusOut}, 16'h0700);
    chk(serialIdOut, SID);
    summarize;
  end
endmodule // cpu_core_status_registers_test

// [verilog/ccs_arith_unit.sv]
// arithmetic result and flag calculation for the accumulator pair
`timescale 1ns/1ps
module ccs_arith_unit (
  input wire ccs_pkg::ccs_alu_op_type op, // operation
  input wire logic [7:0] accIn, // primary operand
  input wire logic [7:0] secondIn, // second accumulator
  input wire logic [7:0] operand, // source byte for add and subtract
  input wire logic carryIn, // current carry flag
  output logic [7:0] accOut, // new primary value
  output logic [7:0] secondOut, // new second value
  output logic carryOut, // new carry flag
  output logic nibbleOut, // new nibble carry flag
  output logic wrapOut // new overflow flag
);

  logic cin;
  logic [8:0] wide;
  logic [4:0] low;
  logic [15:0] product;

  always_comb begin
    cin = 1'b0;
    wide = 9'h000;
    low = 5'h00;
    product = 16'h0000;
    accOut = accIn;
    secondOut = secondIn;
    carryOut = 1'b0;
    nibbleOut = 1'b0;
    wrapOut = 1'b0;
    case (op)
      ccs_pkg::ALU_ADD, ccs_pkg::ALU_ADD_WITH_CARRY_OP: begin
        cin = (op == ccs_pkg::ALU_ADD_WITH_CARRY_OP) ? carryIn : 1'b0;
        wide = {1'b0, accIn} + {1'b0, operand} + {8'h00, cin};
        low = {1'b0, accIn[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
        accOut = wide[7:0];
        carryOut = wide[8]; // [RULE5]
        nibbleOut = low[4]; // [RULE6]
        wrapOut = (accIn[7] == operand[7]) && (wide[7] != accIn[7]); // [RULE7] [RULE8]
      end
      ccs_pkg::ALU_SUBTRACT_WITH_BORROW_OP: begin
        wide = {1'b0, accIn} - {1'b0, operand} - {8'h00, carryIn};
        low = {1'b0, accIn[3:0]} - {1'b0, operand[3:0]} - {4'h0, carryIn};
        accOut = wide[7:0];
        carryOut = wide[8]; // [RULE5]
        nibbleOut = low[4]; // [RULE6]
        wrapOut = (accIn[7] != operand[7]) && (wide[7] != accIn[7]); // [RULE7] [RULE8]
      end
      ccs_pkg::ALU_MUL: begin
        product = {8'h00, accIn} * {8'h00, secondIn}; // [RULE4]
        accOut = product[7:0];
        secondOut = product[15:8];
        wrapOut = |product[15:8]; // [RULE7] [RULE8]
      end
      ccs_pkg::ALU_DIV: begin
        // on a zero divisor both bytes are left as they were
        if (secondIn == 8'h00) begin
          wrapOut = 1'b1; // [RULE7]
        end else begin
          accOut = accIn / secondIn; // [RULE4]
          secondOut = accIn % secondIn;
          wrapOut = 1'b0; // [RULE8]
        end
      end
      default: begin
        accOut = accIn;
      end
    endcase
  end

endmodule // ccs_arith_unit

// [verilog/ccs_pkg.sv]
// constants, field positions and operation codes for the core status registers
package ccs_pkg;

  localparam int DATA_W = 8;
  localparam int ID_BYTES = 4;

  // register addresses in the special-function space
  localparam logic [7:0] ADDR_STACK_TOP = 8'h81;
  localparam logic [7:0] ADDR_STATUS = 8'hd0;
  localparam logic [7:0] ADDR_PRIMARY = 8'he0;
  localparam logic [7:0] ADDR_SECOND = 8'hf0;
  localparam logic [7:0] ADDR_SERIAL0 = 8'hf9;
  localparam logic [7:0] ADDR_SERIAL1 = 8'hfa;
  localparam logic [7:0] ADDR_SERIAL2 = 8'hfb;
  localparam logic [7:0] ADDR_SERIAL3 = 8'hfc;
  localparam logic [7:0] SERIAL_PAGE = 8'h0f;

  // bit space: addresses at or above this reach the register space
  localparam logic [7:0] BIT_SPACE_BASE = 8'h80;

  // reset values
  localparam logic [7:0] STACK_TOP_RESET = 8'h07;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] PRIMARY_RESET = 8'h00;
  localparam logic [7:0] SECOND_RESET = 8'h00;
  localparam logic [31:0] SERIAL_ID_DEFAULT = 32'h5a3c_96e1; // arbitrary value

  // status word field positions
  localparam int CARRY_BIT = 7;
  localparam int NIBBLE_CARRY_BIT = 6;
  localparam int USER_ZERO_BIT = 5;
  localparam int BANK_HI_BIT = 4;
  localparam int BANK_LO_BIT = 3;
  localparam int WRAP_BIT = 2;
  localparam int USER_ONE_BIT = 1;
  localparam int PARITY_BIT = 0;

  // arithmetic operation codes; all but ALU_NONE update the flags
  typedef enum logic [2:0] {
    ALU_NONE,
    ALU_ADD,
    ALU_ADD_WITH_CARRY_OP,
    ALU_SUBTRACT_WITH_BORROW_OP,
    ALU_MUL,
    ALU_DIV
  } ccs_alu_op_type;

endpackage

// [verilog/ccs_status_regs.sv]
// core status registers: stack top, accumulators, status word and serial id
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - a push first increments the stack pointer, then the byte goes there
// RULE2 - stack pointer resets to 0x07 and stays software read/write
// RULE3 - primary accumulator: 8-bit, bit-addressable, resets to zero, arithmetic operand
// RULE4 - second accumulator: 8-bit, bit-addressable, resets to zero, used by multiply/divide
// RULE5 - carry bit 7 set on add carry or subtract borrow, else cleared
// RULE6 - nibble carry bit 6 set on carry into or borrow from upper nibble
// RULE7 - overflow bit 2 set on signed overflow, product above 255, divide by zero
// RULE8 - add, add-carry, subtract, multiply and divide clear overflow otherwise
// RULE9 - bank select bits 4:3 pick one of four eight-byte register banks
// RULE10 - read-only parity bit 0 is one when accumulator has odd ones
// RULE11 - status bits 5 and 1 are software-only storage flags
// RULE12 - status word is bit-addressable, on every page, resets to zero
// RULE13 - stack pointer address answers on every page
// RULE14 - four id bytes form 32 bits, highest address most significant
// RULE15 - id bytes reset to the factory value, readable and writable
// RULE16 - one bank active; first two registers of it are index pointers
// RULE17 - parity follows the accumulator, correct the cycle after any write
module ccs_status_regs #(
  parameter logic [31:0] SERIAL_ID = ccs_pkg::SERIAL_ID_DEFAULT // factory id, arbitrary default
) (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic [7:0] sfrAddr, // direct register address
  input wire logic [7:0] sfrPage, // current register page
  input wire logic sfrWrEn, // byte write strobe
  input wire logic [7:0] sfrWrData, // byte write data
  input wire logic sfrRdEn, // byte read strobe
  output logic [7:0] sfrRdData, // byte read data, one cycle after strobe
  output logic sfrRdHit, // read address was one of ours
  input wire logic [7:0] bitAddr, // direct bit address
  input wire logic bitWrEn, // bit write strobe
  input wire logic bitWrVal, // bit write value
  input wire logic bitRdEn, // bit read strobe
  output logic bitRdData, // bit read value, one cycle after strobe
  input wire logic pushReq, // stack push
  input wire logic popReq, // stack pop
  output logic [7:0] stackAddr, // location for the pushed or popped byte
  input wire ccs_pkg::ccs_alu_op_type aluOp, // arithmetic operation this cycle
  input wire logic [7:0] aluOperand, // source byte for add and subtract
  input wire logic [2:0] regIndex, // general register number
  output logic [7:0] gprAddr, // data address of that register
  input wire logic ptrSel, // which index pointer an indirect access uses
  output logic [7:0] ptrAddr, // data address of that index pointer
  output logic [7:0] primaryOut, // primary accumulator
  output logic [7:0] secondOut, // second accumulator
  output logic [7:0] statusOut, // status word
  output logic [7:0] stackTopOut, // stack pointer
  output logic [31:0] serialIdOut // id, most significant byte from highest address
);

  typedef struct packed {
    logic [7:0] primary;
    logic [7:0] second;
    logic [7:0] status;
    logic [7:0] stackTop;
    logic [ccs_pkg::ID_BYTES-1:0][7:0] serialId;
    logic [7:0] rdData;
    logic rdHit;
    logic bitRd;
    logic [7:0] stackAddr;
    logic [7:0] gprAddr;
    logic [7:0] ptrAddr;
  } ccs_state_type;

  ccs_state_type state_reg;
  ccs_state_type state_next;
  ccs_state_type resetState;

  logic [7:0] aluAcc;
  logic [7:0] aluSecond;
  logic aluCarry;
  logic aluNibble;
  logic aluWrap;
  logic aluActive;

  ccs_arith_unit u_arith (
    .op(aluOp),
    .accIn(state_reg.primary),
    .secondIn(state_reg.second),
    .operand(aluOperand),
    .carryIn(state_reg.status[ccs_pkg::CARRY_BIT]),
    .accOut(aluAcc),
    .secondOut(aluSecond),
    .carryOut(aluCarry),
    .nibbleOut(aluNibble),
    .wrapOut(aluWrap)
  );

  assign aluActive = (aluOp != ccs_pkg::ALU_NONE);

  // byte at an address; the id bytes live on one page, the rest on all pages
  function automatic logic [8:0] readByte(input ccs_state_type s, input logic [7:0] addr,
                                          input logic [7:0] page);
    logic onIdPage;
    onIdPage = (page == ccs_pkg::SERIAL_PAGE);
    case (addr)
      ccs_pkg::ADDR_STACK_TOP: readByte = {1'b1, s.stackTop}; // [RULE13]
      ccs_pkg::ADDR_STATUS: readByte = {1'b1, s.status}; // [RULE12]
      ccs_pkg::ADDR_PRIMARY: readByte = {1'b1, s.primary};
      ccs_pkg::ADDR_SECOND: readByte = {1'b1, s.second};
      ccs_pkg::ADDR_SERIAL0: readByte = {onIdPage, onIdPage ? s.serialId[0] : 8'h00};
      ccs_pkg::ADDR_SERIAL1: readByte = {onIdPage, onIdPage ? s.serialId[1] : 8'h00};
      ccs_pkg::ADDR_SERIAL2: readByte = {onIdPage, onIdPage ? s.serialId[2] : 8'h00};
      ccs_pkg::ADDR_SERIAL3: readByte = {onIdPage, onIdPage ? s.serialId[3] : 8'h00};
      default: readByte = 9'h000;
    endcase
  endfunction

  always_comb begin
    resetState = '0;
    resetState.primary = ccs_pkg::PRIMARY_RESET; // [RULE3]
    resetState.second = ccs_pkg::SECOND_RESET; // [RULE4]
    resetState.status = ccs_pkg::STATUS_RESET; // [RULE12]
    resetState.stackTop = ccs_pkg::STACK_TOP_RESET; // [RULE2]
    resetState.serialId = SERIAL_ID; // [RULE15]
  end

  always_comb begin
    logic [7:0] byteBase;
    logic [2:0] bitPos;
    logic [8:0] rdWord;
    logic isRegBit;
    byteBase = {bitAddr[7:3], 3'b000};
    bitPos = bitAddr[2:0];
    rdWord = 9'h000;
    isRegBit = (bitAddr >= ccs_pkg::BIT_SPACE_BASE);
    state_next = state_reg;

    // arithmetic results
    if (aluActive) begin
      state_next.primary = aluAcc; // [RULE3]
      state_next.second = aluSecond; // [RULE4]
    end

    // stack pointer moves before the push byte is placed
    if (pushReq) begin
      state_next.stackTop = state_reg.stackTop + 8'h01; // [RULE1]
      state_next.stackAddr = state_reg.stackTop + 8'h01; // [RULE1]
    end else if (popReq) begin
      state_next.stackTop = state_reg.stackTop - 8'h01;
      state_next.stackAddr = state_reg.stackTop;
    end

    // bit writes reach only the bit-addressable registers
    if (bitWrEn && isRegBit) begin
      case (byteBase)
        ccs_pkg::ADDR_PRIMARY: state_next.primary[bitPos] = bitWrVal; // [RULE3]
        ccs_pkg::ADDR_SECOND: state_next.second[bitPos] = bitWrVal; // [RULE4]
        ccs_pkg::ADDR_STATUS: state_next.status[bitPos] = bitWrVal; // [RULE11] [RULE12]
        default: state_next.gprAddr = state_next.gprAddr;
      endcase
    end

    // byte writes win over bit writes, pushes and arithmetic data
    if (sfrWrEn) begin
      case (sfrAddr)
        ccs_pkg::ADDR_STACK_TOP: state_next.stackTop = sfrWrData; // [RULE2] [RULE13]
        ccs_pkg::ADDR_STATUS: state_next.status = sfrWrData; // [RULE11] [RULE12]
        ccs_pkg::ADDR_PRIMARY: state_next.primary = sfrWrData; // [RULE3]
        ccs_pkg::ADDR_SECOND: state_next.second = sfrWrData; // [RULE4]
        ccs_pkg::ADDR_SERIAL0: begin
          if (sfrPage == ccs_pkg::SERIAL_PAGE) state_next.serialId[0] = sfrWrData; // [RULE15]
        end
        ccs_pkg::ADDR_SERIAL1: begin
          if (sfrPage == ccs_pkg::SERIAL_PAGE) state_next.serialId[1] = sfrWrData; // [RULE15]
        end
        ccs_pkg::ADDR_SERIAL2: begin
          if (sfrPage == ccs_pkg::SERIAL_PAGE) state_next.serialId[2] = sfrWrData; // [RULE15]
        end
        ccs_pkg::ADDR_SERIAL3: begin
          if (sfrPage == ccs_pkg::SERIAL_PAGE) state_next.serialId[3] = sfrWrData; // [RULE15]
        end
        default: state_next.rdHit = state_next.rdHit;
      endcase
    end

    // hardware flag results win over a software write in the same cycle
    if (aluActive) begin
      state_next.status[ccs_pkg::CARRY_BIT] = aluCarry; // [RULE5]
      state_next.status[ccs_pkg::NIBBLE_CARRY_BIT] = aluNibble; // [RULE6]
      state_next.status[ccs_pkg::WRAP_BIT] = aluWrap; // [RULE7] [RULE8]
    end

    // parity is read-only and always follows the next accumulator value
    state_next.status[ccs_pkg::PARITY_BIT] = ^state_next.primary; // [RULE10] [RULE17]

    // reads see the values before this cycle's writes
    if (sfrRdEn) begin
      rdWord = readByte(state_reg, sfrAddr, sfrPage);
      state_next.rdData = rdWord[7:0];
      state_next.rdHit = rdWord[8];
    end
    if (bitRdEn) begin
      rdWord = readByte(state_reg, byteBase, sfrPage);
      state_next.bitRd = isRegBit && rdWord[8] && rdWord[bitPos];
    end

    // register number and index pointers map through the active bank
    state_next.gprAddr = {3'b000, state_next.status[ccs_pkg::BANK_HI_BIT:ccs_pkg::BANK_LO_BIT],
                          regIndex}; // [RULE9] [RULE16]
    state_next.ptrAddr = {3'b000, state_next.status[ccs_pkg::BANK_HI_BIT:ccs_pkg::BANK_LO_BIT],
                          2'b00, ptrSel}; // [RULE16]
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= resetState;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign sfrRdData = state_reg.rdData;
  assign sfrRdHit = state_reg.rdHit;
  assign bitRdData = state_reg.bitRd;
  assign stackAddr = state_reg.stackAddr;
  assign gprAddr = state_reg.gprAddr;
  assign ptrAddr = state_reg.ptrAddr;
  assign primaryOut = state_reg.primary;
  assign secondOut = state_reg.second;
  assign statusOut = state_reg.status;
  assign stackTopOut = state_reg.stackTop;
  assign serialIdOut = state_reg.serialId; // [RULE14]

endmodule // ccs_status_regs
